/* File: pkg/prescaler_pkg.sv */
/*
 * Constants, types and register layout for the shared timer prescaler.
 * Assumes a 32-bit AXI4-Lite register bus and one system clock.
 */
// Contract
// (RL1) Prescaler counts every system clock, free running, shared by both timers.
// (RL2) Each timer has its own clock source selection from the shared taps.
// (RL3) Prescaled tap enable gives first count within 1 to N+1 cycles.
// (RL4) Selection 1 counts every system clock, no division.
// (RL5) Four divided taps: divide by 8, 64, 256 and 1024.
// (RL6) Count pin sampled every clock, synchronised, then edge detected.
// (RL7) Synchroniser flops on rising clock, behind a latch open while clock high.
// (RL8) One count pulse per rising edge at selection 7, falling at 6.
// (RL9) Counter updates 2.5 to 3.5 clocks after a pin edge; the extra level stage here makes it 3.5 to 4.5.
// (RL10) Other side changes external selection only while pin stable a cycle.
// (RL11) Other side keeps each pin half period above one clock.
// (RL12) Pin clock goes to the counter after edge detection, never divided.
// (RL13) Sync hold mode keeps written reset bits; clearing it releases both.
// (RL14) Writing one to shared reset bit resets prescaler; self clears unless held.
// (RL15) Shared prescaler reset restarts division phase for every attached timer.
// (RL16) Selection 0 gives no count clock; timer stopped.
// (RL17) Prescaler is a free-running 10-bit counter; taps are enable pulses.
package prescaler_pkg;

	// Register indexes; byte address is four times the index
	localparam logic [7:0] GTC_INDEX  = 8'h23;
	localparam logic [7:0] CSEL_INDEX = 8'h24;
	localparam logic [7:0] STAT_INDEX = 8'h25;
	localparam logic [7:0] GTC_ADDR   = {GTC_INDEX[5:0], 2'b00};
	localparam logic [7:0] CSEL_ADDR  = {CSEL_INDEX[5:0], 2'b00};
	localparam logic [7:0] STAT_ADDR  = {STAT_INDEX[5:0], 2'b00};

	// Field positions
	localparam int SYNC_MODE_BIT  = 7;
	localparam int ASYNC_PSR_BIT  = 1;
	localparam int SHARED_PSR_BIT = 0;
	localparam int CSEL0_LSB      = 0;
	localparam int CSEL1_LSB      = 4;
	localparam int STAT_LEVEL_LSB = 16;

	// Values after reset
	localparam logic [7:0] GTC_RESET  = 8'h00;
	localparam logic [7:0] CSEL_RESET = 8'h00;

	// Prescaler width and tap positions
	localparam int PRESC_W     = 10;
	localparam int DIV8_LOG    = 3;
	localparam int DIV64_LOG   = 6;
	localparam int DIV256_LOG  = 8;
	localparam int DIV1024_LOG = 10;

	// Bus responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		CS_STOP     = 3'h0,
		CS_SYS      = 3'h1,
		CS_DIV8     = 3'h2,
		CS_DIV64    = 3'h3,
		CS_DIV256   = 3'h4,
		CS_DIV1024  = 3'h5,
		CS_EXT_FALL = 3'h6,
		CS_EXT_RISE = 3'h7
	} clk_sel_t;

	typedef struct packed {
		logic ext_rise;
		logic ext_fall;
		logic div1024;
		logic div256;
		logic div64;
		logic div8;
	} count_sources_t;

endpackage

/* File: logic/ext_pin_sync.sv */
/*
 * Count pin synchroniser and edge detector for one timer.
 * Assumes the pin is asynchronous and changes no faster than half the clock.
 */
`timescale 1ns/1ps
`default_nettype none
module ext_pin_sync
(
	// Clock and reset
	input  wire logic aclk,
	input  wire logic aresetn,
	// Raw pin
	input  wire logic pin,
	// Edge pulses and settled level
	output logic      rise,
	output logic      fall,
	output logic      level
);
	import prescaler_pkg::*;

	logic pin_latch;
	logic sync_a;
	logic sync_b;

	// Latch holds the pin through the low phase
	always_latch
	begin
		if (aclk)
			pin_latch <= pin; // RL7
	end

	// Two stage synchroniser plus history for the detector
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			sync_a <= 1'b0;
			sync_b <= 1'b0;
			level  <= 1'b0;
		end
		else
		begin
			sync_a <= pin_latch; // RL6 RL7
			sync_b <= sync_a;
			level  <= sync_b;
		end
	end

	// Registered edge pulses, one per edge
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rise <= 1'b0;
			fall <= 1'b0;
		end
		else
		begin
			rise <= sync_b & ~level; // RL8 RL9
			fall <= ~sync_b & level; // RL8 RL9
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_rise_single: assert property (rise |=> !rise) // RL8
		else $error("rise pulse longer than one cycle");
	a_edge_timing: assert property ((sync_b && !level) |=> (rise && !fall)) // RL9
		else $error("rising edge not reported next cycle");
	a_fall_cause: assert property (fall |-> $past(level) && !$past(sync_b, 1) ) // RL6
		else $error("fall pulse without a settled falling edge");
	c_rise_seen: cover property (rise);

endmodule
`default_nettype wire

/* File: logic/clock_select.sv */
/*
 * Per-timer clock source selection from the shared prescaler taps.
 * Assumes tap and edge inputs are single-cycle enables on aclk.
 */
`timescale 1ns/1ps
`default_nettype none
module clock_select
(
	// Clock and reset, used by checks only
	input  wire logic                          aclk,
	input  wire logic                          aresetn,
	// Selection and candidate sources
	input  wire prescaler_pkg::clk_sel_t       sel,
	input  wire prescaler_pkg::count_sources_t src,
	// Count enable to the timer
	output logic                               count
);
	import prescaler_pkg::*;

	// One multiplexer per timer, taps are never re-divided
	always_comb
	begin
		unique case (sel)
			CS_STOP:     count = 1'b0;         // RL16
			CS_SYS:      count = 1'b1;         // RL4
			CS_DIV8:     count = src.div8;     // RL2 RL5
			CS_DIV64:    count = src.div64;    // RL5
			CS_DIV256:   count = src.div256;   // RL5
			CS_DIV1024:  count = src.div1024;  // RL5
			CS_EXT_FALL: count = src.ext_fall; // RL8 RL12
			CS_EXT_RISE: count = src.ext_rise; // RL8 RL12
		endcase
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_stop_quiet: assert property ((sel == CS_STOP)[*2] |-> !count && !$past(count)) // RL16
		else $error("count while stopped");
	a_sys_every: assert property (sel == CS_SYS |-> count) // RL4
		else $error("system tap missed a cycle");
	a_ext_direct: assert property (sel == CS_EXT_RISE |-> count == src.ext_rise) // RL12
		else $error("external count not passed straight through");

endmodule
`default_nettype wire

/* File: logic/shared_timer_prescaler.sv */
/*
 * Shared prescaler, pin synchronisers and clock select for two timers,
 * with an AXI4-Lite register slave for control and status.
 * Assumes one 100 MHz clock, synchronous active-low reset, and that the
 * count pins come from outside the clock domain.
 */
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/1ps
`default_nettype none
module shared_timer_prescaler #(
	parameter int ADDR_W   = 8,
	parameter int N_TIMERS = 2
) (
	// Clock and reset
	input  wire logic                 aclk,
	input  wire logic                 aresetn,
	// AXI4-Lite write address and data
	input  wire logic [ADDR_W-1:0]    awaddr,
	input  wire logic                 awvalid,
	output logic                      awready,
	input  wire logic [31:0]          wdata,
	input  wire logic [3:0]           wstrb,
	input  wire logic                 wvalid,
	output logic                      wready,
	// AXI4-Lite write response
	output logic [1:0]                bresp,
	output logic                      bvalid,
	input  wire logic                 bready,
	// AXI4-Lite read
	input  wire logic [ADDR_W-1:0]    araddr,
	input  wire logic                 arvalid,
	output logic                      arready,
	output logic [31:0]               rdata,
	output logic [1:0]                rresp,
	output logic                      rvalid,
	input  wire logic                 rready,
	// External count pins, one per timer
	input  wire logic [N_TIMERS-1:0]  ext_count_pin,
	// Count enables to the timers
	output logic [N_TIMERS-1:0]       timer_count_clock,
	// Prescaler reset levels
	output logic                      shared_prescaler_reset,
	output logic                      async_prescaler_reset
);
	import prescaler_pkg::*;

	logic                aw_held;
	logic [ADDR_W-1:0]   aw_addr;
	logic                w_held;
	logic [31:0]         w_data;
	logic [3:0]          w_strb;
	logic                do_write;
	logic                wr_gtc;
	logic                wr_csel;
	logic                wr_hit;
	logic                sync_hold_mode;
	logic [7:0]          clock_source_select;
	logic [PRESC_W-1:0]  presc_count;
	logic                tick8;
	logic                tick64;
	logic                tick256;
	logic                tick1024;
	logic [N_TIMERS-1:0] pin_level;
	logic [31:0]         next_rdata;
	logic [1:0]          next_rresp;
	clk_sel_t            sel [N_TIMERS];

	// Address and data are taken separately, in any order
	assign awready  = !aw_held && !bvalid;
	assign wready   = !w_held && !bvalid;
	assign do_write = aw_held && w_held && !bvalid;
	assign wr_gtc   = do_write && w_strb[0] && (aw_addr == ADDR_W'(GTC_ADDR));
	assign wr_csel  = do_write && w_strb[0] && (aw_addr == ADDR_W'(CSEL_ADDR));
	assign wr_hit   = (aw_addr == ADDR_W'(GTC_ADDR)) || (aw_addr == ADDR_W'(CSEL_ADDR))
		|| (aw_addr == ADDR_W'(STAT_ADDR));

	// Write channel holding registers
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held <= 1'b0;
			aw_addr <= '0;
			w_held  <= 1'b0;
			w_data  <= '0;
			w_strb  <= '0;
		end
		else if (do_write)
		begin
			aw_held <= 1'b0;
			w_held  <= 1'b0;
		end
		else
		begin
			if (awvalid && awready)
			begin
				aw_held <= 1'b1;
				aw_addr <= awaddr;
			end
			if (wvalid && wready)
			begin
				w_held <= 1'b1;
				w_data <= wdata;
				w_strb <= wstrb;
			end
		end
	end

	// Write response; status register ignores writes but answers OKAY
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			bvalid <= 1'b0;
			bresp  <= RESP_OKAY;
		end
		else if (do_write)
		begin
			bvalid <= 1'b1;
			bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
		end
		else if (bready)
			bvalid <= 1'b0;
	end

	// Control register: hold mode keeps written reset bits asserted
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			sync_hold_mode         <= GTC_RESET[SYNC_MODE_BIT];
			shared_prescaler_reset <= GTC_RESET[SHARED_PSR_BIT];
			async_prescaler_reset  <= GTC_RESET[ASYNC_PSR_BIT];
		end
		else if (wr_gtc)
		begin
			sync_hold_mode         <= w_data[SYNC_MODE_BIT];  // RL13
			shared_prescaler_reset <= w_data[SHARED_PSR_BIT]; // RL14
			async_prescaler_reset  <= w_data[ASYNC_PSR_BIT];  // RL13
		end
		else if (!sync_hold_mode)
		begin
			// Self clear after one cycle, or on leaving hold mode
			shared_prescaler_reset <= 1'b0; // RL13 RL14
			async_prescaler_reset  <= 1'b0; // RL13
		end
	end

	// Clock source selections, one field per timer
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			clock_source_select <= CSEL_RESET;
		else if (wr_csel)
			clock_source_select <= w_data[7:0]; // RL2
	end

	assign sel[0] = clk_sel_t'(clock_source_select[CSEL0_LSB +: 3]);
	assign sel[1] = clk_sel_t'(clock_source_select[CSEL1_LSB +: 3]);

	// Free-running prescaler, ignores every clock selection
	always_ff @(posedge aclk)
	begin
		if (!aresetn || shared_prescaler_reset)
			presc_count <= '0; // RL15
		else
			presc_count <= PRESC_W'(presc_count + 1'b1); // RL1 RL17
	end

	// Taps are one-cycle enables when the low bits wrap; a held reset
	// suppresses them so attached timers stay halted
	assign tick8    = &presc_count[DIV8_LOG-1:0] && !shared_prescaler_reset;       // RL5 RL17
	assign tick64   = &presc_count[DIV64_LOG-1:0] && !shared_prescaler_reset;      // RL5
	assign tick256  = &presc_count[DIV256_LOG-1:0] && !shared_prescaler_reset;     // RL5
	assign tick1024 = &presc_count[DIV1024_LOG-1:0] && !shared_prescaler_reset;    // RL3 RL5

	// Per-timer pin path and selection
	for (genvar t = 0; t < N_TIMERS; t++)
	begin : g_timer
		logic           rise;
		logic           fall;
		count_sources_t src;

		ext_pin_sync u_sync (
			.aclk    (aclk),
			.aresetn (aresetn),
			.pin     (ext_count_pin[t]),
			.rise    (rise),
			.fall    (fall),
			.level   (pin_level[t])
		);

		// Pin edges bypass the dividers
		assign src = '{ext_rise: rise, ext_fall: fall, div1024: tick1024, // RL12
			div256: tick256, div64: tick64, div8: tick8};

		clock_select u_sel (
			.aclk    (aclk),
			.aresetn (aresetn),
			.sel     (sel[t]),
			.src     (src),
			.count   (timer_count_clock[t])
		);
	end

	// Read data selection
	always_comb
	begin
		next_rdata = 32'h0000_0000;
		next_rresp = RESP_OKAY;
		if (araddr == ADDR_W'(GTC_ADDR))
		begin
			next_rdata[SYNC_MODE_BIT]  = sync_hold_mode;
			next_rdata[ASYNC_PSR_BIT]  = async_prescaler_reset;
			next_rdata[SHARED_PSR_BIT] = shared_prescaler_reset;
		end
		else if (araddr == ADDR_W'(CSEL_ADDR))
			next_rdata[7:0] = clock_source_select;
		else if (araddr == ADDR_W'(STAT_ADDR))
		begin
			next_rdata[PRESC_W-1:0] = presc_count;
			next_rdata[STAT_LEVEL_LSB +: N_TIMERS] = pin_level;
		end
		else
			next_rresp = RESP_SLVERR;
	end

	// Read channel: one read in flight, answer the cycle after address
	assign arready = !rvalid;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rvalid <= 1'b0;
			rdata  <= 32'h0000_0000;
			rresp  <= RESP_OKAY;
		end
		else if (arvalid && arready)
		begin
			rvalid <= 1'b1;
			rdata  <= next_rdata;
			rresp  <= next_rresp;
		end
		else if (rready)
			rvalid <= 1'b0;
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_presc_free_run: assert property ( // RL1
		!shared_prescaler_reset |=> presc_count == PRESC_W'($past(presc_count) + 1'b1)
	) else $error("prescaler did not advance");

	a_presc_restart: assert property ( // RL15
		shared_prescaler_reset |=> presc_count == '0 && !tick8
	) else $error("prescaler reset did not restart phase");

	a_reset_selfclear: assert property ( // RL14
		(shared_prescaler_reset && !sync_hold_mode && !wr_gtc) |=> !shared_prescaler_reset
	) else $error("shared reset bit did not clear");

	a_hold_keeps_reset: assert property ( // RL13
		(sync_hold_mode && shared_prescaler_reset && !wr_gtc) |=> shared_prescaler_reset
	) else $error("held reset bit dropped");

	a_hold_release: assert property ( // RL13
		(wr_gtc && !w_data[SYNC_MODE_BIT]) |=> ##1 (!shared_prescaler_reset
			&& !async_prescaler_reset) || wr_gtc || $past(wr_gtc)
	) else $error("release did not clear both reset bits");

	a_div8_spacing: assert property ( // RL5
		tick8 ##1 (!shared_prescaler_reset)[*8] |-> tick8
	) else $error("divide by 8 tap period wrong");

	a_tap_nesting: assert property ( // RL17
		tick1024 |-> tick256 && tick64 && tick8 && presc_count == '1
	) else $error("taps not aligned to counter wrap");

	a_first_count: assert property ( // RL3
		($changed(sel[1]) && sel[1] == CS_DIV8) |->
			##[0:8] (timer_count_clock[1] || shared_prescaler_reset || sel[1] != CS_DIV8)
	) else $error("first prescaled count later than N+1");

	// Held prescaler reset must halt every prescaled timer, not only one
	a_halt_timer0: assert property ( // RL13
		(shared_prescaler_reset && sel[0] inside {CS_DIV8, CS_DIV64, CS_DIV256, CS_DIV1024})
			|-> !timer_count_clock[0]
	) else $error("timer 0 counted while prescaler held");

	a_halt_timer1: assert property ( // RL15
		(shared_prescaler_reset && sel[1] inside {CS_DIV8, CS_DIV64, CS_DIV256, CS_DIV1024})
			|-> !timer_count_clock[1]
	) else $error("timer 1 counted while prescaler held");

	a_async_selfclear: assert property ( // RL13
		(async_prescaler_reset && !sync_hold_mode && !wr_gtc) |=> !async_prescaler_reset
	) else $error("second reset bit did not clear");

	c_div1024_tick: cover property (tick1024 && sel[1] == CS_DIV1024);
	c_hold_release: cover property (sync_hold_mode ##1 !sync_hold_mode);
	c_ext_count: cover property (sel[0] == CS_EXT_RISE && timer_count_clock[0]);
	c_unmapped: cover property (bvalid && bresp == RESP_SLVERR);

endmodule
`default_nettype wire

/* File: bench/timer_unit_model.sv */
/*
 * Behavioural model of the two timer/counter units fed by the prescaler.
 * Assumes the count enables are single-cycle strobes on aclk.
 */
`timescale 1ns/1ps
`default_nettype none
module timer_unit_model
(
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// Count enables, bit 0 first unit
	input  wire logic [1:0]  count_en,
	// Running totals
	output logic      [31:0] count_a,
	output logic      [31:0] count_b
);
	// Units advance only at edges where their enable is high
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			count_a <= 32'h0;
			count_b <= 32'h0;
		end
		else
		begin
			count_a <= count_a + {31'h0, count_en[0]};
			count_b <= count_b + {31'h0, count_en[1]};
		end
	end
endmodule
`default_nettype wire

/* File: bench/tb_top.sv */
/*
 * Self-checking bench for the shared prescaler block.
 * Assumes the register map and timing given in the package.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import prescaler_pkg::*;
	typedef struct packed {clk_sel_t s0; clk_sel_t s1; logic [31:0] e0; logic [31:0] e1;} row_t;
	localparam int LIMIT = 20000;
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic [7:0]  awaddr = 8'h0, araddr = 8'h0;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [3:0]  wstrb = 4'h0;
	logic [1:0]  ext_count_pin = 2'h0;
	logic        awready, wready, bvalid, arready, rvalid, shared_prescaler_reset;
	logic        async_prescaler_reset;
	logic [1:0]  bresp, rresp, timer_count_clock;
	logic [31:0] rdata, count_a, count_b, rd, base_a, base_b;
	logic [1:0]  rs;
	int          failures = 0, total_checks = 0, cycles = 0, n, i;
	// Window of 2048 edges holds a whole number of every tap period
	row_t rows [4] = '{'{CS_SYS, CS_DIV8, 32'h800, 32'h100},
		'{CS_DIV64, CS_DIV256, 32'h20, 32'h8}, '{CS_DIV1024, CS_STOP, 32'h2, 32'h0},
		'{CS_STOP, CS_DIV1024, 32'h0, 32'h2}};

	shared_timer_prescaler i_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready), .ext_count_pin(ext_count_pin), .timer_count_clock(timer_count_clock),
		.shared_prescaler_reset(shared_prescaler_reset),
		.async_prescaler_reset(async_prescaler_reset));
	timer_unit_model i_units (.aclk(aclk), .aresetn(aresetn), .count_en(timer_count_clock),
		.count_a(count_a), .count_b(count_b));

	// Clock and hang guard
	always #5 aclk = ~aclk;
	always @(posedge aclk)
	begin
		cycles++;
		if (cycles == LIMIT)
		begin
			failures++;
			summarize();
		end
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
	begin
		total_checks++;
		if (seen !== exp)
		begin
			failures++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	end
	endtask

	// Write: both channels offered together, each dropped once taken
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
		output logic [1:0] r);
		bit aw, w;
	begin
		aw = 1;
		w = 1;
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (aw || w)
		begin
			@(posedge aclk);
			if (aw && awready === 1'b1)
			begin
				aw = 0;
				awvalid <= 1'b0;
			end
			if (w && wready === 1'b1)
			begin
				w = 0;
				wvalid <= 1'b0;
			end
		end
		while (bvalid !== 1'b1)
			@(posedge aclk);
		r = bresp;
		bready <= 1'b0;
		@(posedge aclk);
	end
	endtask

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
	begin
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
			@(posedge aclk);
		while (arready !== 1'b1);
		arvalid <= 1'b0;
		while (rvalid !== 1'b1)
			@(posedge aclk);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
		@(posedge aclk);
	end
	endtask

	task summarize;
	begin
		if (failures == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	end
	endtask

	// Main sequence
	initial
	begin
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		axi_rd(GTC_ADDR, rd, rs);
		chk(rd, {24'h0, GTC_RESET});
		chk({30'h0, rs}, {30'h0, RESP_OKAY});
		axi_rd(CSEL_ADDR, rd, rs);
		chk(rd, {24'h0, CSEL_RESET});
		chk({30'h0, timer_count_clock}, 32'h0);
		// Rate table per select pair
		for (i = 0; i < 4; i++)
		begin
			axi_wr(CSEL_ADDR, {25'h0, rows[i].s1, 1'b0, rows[i].s0}, 4'hF, rs);
			base_a = count_a;
			base_b = count_b;
			repeat (2048) @(posedge aclk);
			chk(count_a - base_a, rows[i].e0);
			chk(count_b - base_b, rows[i].e1);
		end
		// First count after enabling a divided tap
		axi_wr(CSEL_ADDR, 32'h53, 4'hF, rs);
		n = 0;
		do
		begin
			@(posedge aclk);
			n++;
		end
		while (timer_count_clock[0] !== 1'b1 && n < 200);
		chk(32'(n >= 1 && n <= 66), 32'h1);
		// Shared reset self clears and restarts the count
		axi_wr(GTC_ADDR, 32'h1, 4'hF, rs);
		axi_rd(STAT_ADDR, rd, rs);
		chk(32'(rd[9:0] < 10'h8), 32'h1);
		axi_rd(GTC_ADDR, rd, rs);
		chk(rd, 32'h0);
		// Hold mode keeps both reset bits and freezes the taps
		axi_wr(GTC_ADDR, 32'h83, 4'hF, rs);
		axi_rd(GTC_ADDR, rd, rs);
		chk(rd, 32'h83);
		chk({30'h0, shared_prescaler_reset, async_prescaler_reset}, 32'h3);
		base_a = count_a;
		repeat (200) @(posedge aclk);
		axi_rd(STAT_ADDR, rd, rs);
		chk({22'h0, rd[9:0]}, 32'h0);
		chk(count_a - base_a, 32'h0);
		// Leaving hold mode with bits written high: hardware must clear them
		axi_wr(GTC_ADDR, 32'h3, 4'hF, rs);
		axi_rd(GTC_ADDR, rd, rs);
		chk(rd, 32'h0);
		chk({30'h0, shared_prescaler_reset, async_prescaler_reset}, 32'h0);
		// Strobe off, unmapped address
		axi_wr(GTC_ADDR, 32'h80, 4'h0, rs);
		chk({30'h0, rs}, {30'h0, RESP_OKAY});
		axi_rd(GTC_ADDR, rd, rs);
		chk(rd, 32'h0);
		axi_wr(8'h00, 32'h1, 4'hF, rs);
		chk({30'h0, rs}, {30'h0, RESP_SLVERR});
		axi_rd(8'h00, rd, rs);
		chk({rd[29:0], rs}, {30'h0, RESP_SLVERR});
		// Pin counting, select changed while pins still; half periods of 4
		axi_wr(CSEL_ADDR, 32'h67, 4'hF, rs);
		base_a = count_a;
		base_b = count_b;
		ext_count_pin <= 2'h3;
		n = 0;
		do
		begin
			@(posedge aclk);
			n++;
		end
		while (timer_count_clock[0] !== 1'b1 && n < 20);
		chk(32'(n >= 3 && n <= 4), 32'h1);
		repeat (2) @(posedge aclk);
		for (i = 1; i < 10; i++)
		begin
			ext_count_pin <= {2{~i[0]}};
			repeat (4) @(posedge aclk);
		end
		repeat (6) @(posedge aclk);
		chk(count_a - base_a, 32'h5);
		chk(count_b - base_b, 32'h5);
		// Settled pin levels show in the status word
		ext_count_pin <= 2'h3;
		repeat (4) @(posedge aclk);
		axi_rd(STAT_ADDR, rd, rs);
		chk({30'h0, rd[17:16]}, 32'h3);
		ext_count_pin <= 2'h0;
		repeat (6) @(posedge aclk);
		// Reset in mid-run clears hold state and selections
		axi_wr(GTC_ADDR, 32'h83, 4'hF, rs);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		chk({28'h0, shared_prescaler_reset, async_prescaler_reset, timer_count_clock}, 32'h0);
		axi_rd(GTC_ADDR, rd, rs);
		chk(rd, {24'h0, GTC_RESET});
		axi_rd(CSEL_ADDR, rd, rs);
		chk(rd, {24'h0, CSEL_RESET});
		summarize();
	end
endmodule
`default_nettype wire
